// ---- src/ram_alarm_unit.sv ----
// Purpose: two alarms comparing the time counters, flags, interrupt pins, avalon register port
// Assumes: time inputs are bcd, stable while sec_tick_i pulses for one cycle per second
// Notes: alarm byte bit 7 holds one repeat bit, bits 6:0 hold the bcd value
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ram_consts.svh"

// Function
// - a repeat code outside the six defined ones behaves as once per second.
// - an alarm flag sets when the time matches the alarm in every field its repeat bits select.
// - a host read of the flag register clears the alarm flags that it returns as set.
// - that read still returns the flags as set; only a later read shows zero.
// - with first interrupt enable and output enable set, the shared output asserts on the first flag.
// - with second interrupt enable set, the second output asserts on the second flag.
// - a zero date value with all repeat bits zero disables that alarm.
// - while the address pointer rests on the flag register no alarm flag is set.
// - the shared and second outputs drop when the flag read clears the flags; irq_o drops on the status read.
// - in backup the shared output is driven only when alarm-in-backup enable is set.
// - an output asserted in backup holds until main supply returns and the flags are read.
// - with second-alarm enable set, indices 14h to 18h act as the second alarm.
// - second-alarm enable is zero after reset.
// - with the second alarm disabled its five bytes are plain read/write memory.
// - in backup the second output asserts only with backup enable and second interrupt enable.
// - repeat bits 5..1 all one every second, then each trailing zero widens the match.
module ram_alarm_unit (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic [6:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic sec_tick_i,
	input wire logic [6:0] time_sec_i,
	input wire logic [6:0] time_min_i,
	input wire logic [5:0] time_hour_i,
	input wire logic [5:0] time_date_i,
	input wire logic [4:0] time_month_i,
	input wire logic backup_i,
	output logic shared_irq_test_out_o,
	output logic second_alarm_irq_out_o,
	output logic irq_o
);

	logic [7:0] alarm_q [0:9];
	logic [7:0] ctrl_q;
	logic first_alarm_hit_flag_q;
	logic second_alarm_hit_flag_q;
	logic [4:0] ptr_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic hold1_q;
	logic hold2_q;
	logic [4:0] idx;
	logic req;
	logic rd_acc;
	logic wr_acc;
	logic hit1;
	logic hit2;
	logic set1;
	logic set2;
	logic clr1;
	logic clr2;
	logic flags_rd;
	logic out1;
	logic out2;
	logic [7:0] rd_val;
	logic [4:0] a1_rpt;
	logic [4:0] a2_rpt;

	// repeat bits from bit 5 down to bit 1
	function automatic ram_pkg::ram_mode_t rpt_mode(input logic [4:0] rpt);
		ram_pkg::ram_mode_t m;
		m = ram_pkg::RAM_EVERY_SEC;
		unique case (rpt)
			5'h1f: m = ram_pkg::RAM_EVERY_SEC;
			5'h1e: m = ram_pkg::RAM_EVERY_MIN;
			5'h1c: m = ram_pkg::RAM_EVERY_HOUR;
			5'h18: m = ram_pkg::RAM_EVERY_DAY;
			5'h10: m = ram_pkg::RAM_EVERY_MONTH;
			5'h00: m = ram_pkg::RAM_EVERY_YEAR;
			default: m = ram_pkg::RAM_EVERY_SEC;
		endcase
		return m;
	endfunction

	// repeat field gathered from bit 7 of the five alarm bytes, month first
	function automatic logic [4:0] rpt_of(input logic [7:0] mo, input logic [7:0] da,
			input logic [7:0] hr, input logic [7:0] mi, input logic [7:0] se);
		return {mo[`RAM_ALARM_RPT_BIT], da[`RAM_ALARM_RPT_BIT], hr[`RAM_ALARM_RPT_BIT],
			mi[`RAM_ALARM_RPT_BIT], se[`RAM_ALARM_RPT_BIT]};
	endfunction

	// alarm bytes in order month, date, hour, minute, second
	function automatic logic alarm_hit(input logic [7:0] mo, input logic [7:0] da,
			input logic [7:0] hr, input logic [7:0] mi, input logic [7:0] se,
			input logic [6:0] t_se, input logic [6:0] t_mi, input logic [5:0] t_hr,
			input logic [5:0] t_da, input logic [4:0] t_mo);
		logic [4:0] rpt;
		logic m_se;
		logic m_mi;
		logic m_hr;
		logic m_da;
		logic m_mo;
		logic h;
		rpt = rpt_of(mo, da, hr, mi, se);
		m_se = (se[6:0] == t_se);
		m_mi = (mi[6:0] == t_mi);
		m_hr = (hr[5:0] == t_hr);
		m_da = (da[5:0] == t_da);
		m_mo = (mo[4:0] == t_mo);
		h = 1'b0;
		unique case (rpt_mode(rpt))
			ram_pkg::RAM_EVERY_SEC: h = 1'b1;
			ram_pkg::RAM_EVERY_MIN: h = m_se;
			ram_pkg::RAM_EVERY_HOUR: h = m_se & m_mi;
			ram_pkg::RAM_EVERY_DAY: h = m_se & m_mi & m_hr;
			ram_pkg::RAM_EVERY_MONTH: h = m_se & m_mi & m_hr & m_da;
			ram_pkg::RAM_EVERY_YEAR: h = m_se & m_mi & m_hr & m_da & m_mo;
		endcase
		// zero date and zero repeat field means switched off
		if (rpt == 5'h00 && da[5:0] == 6'h00) begin
			h = 1'b0;
		end
		return h;
	endfunction

	assign idx = avs_address_i[6:2];
	assign req = avs_read_i | avs_write_i;
	// one wait cycle: data is looked up on the first edge, taken on the second
	assign avs_waitrequest_o = req & ~ack_q;
	assign rd_acc = avs_read_i & ack_q;
	assign wr_acc = avs_write_i & ack_q & avs_byteenable_i[0];
	assign avs_readdata_o = rdata_q;
	assign flags_rd = rd_acc & (idx == `RAM_IDX_FLAGS);

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_comb begin
		rd_val = 8'h00;
		if (idx >= `RAM_IDX_A1_MONTH && idx <= `RAM_IDX_A1_SEC) begin
			rd_val = alarm_q[4'(idx - `RAM_IDX_A1_MONTH)];
		end else if (idx >= `RAM_IDX_A2_MONTH && idx <= `RAM_IDX_A2_SEC) begin
			rd_val = alarm_q[4'(idx - `RAM_IDX_A2_MONTH + 5'h05)];
		end else if (idx == `RAM_IDX_FLAGS) begin
			rd_val[`RAM_FLAG_FIRST_HIT] = first_alarm_hit_flag_q;
			rd_val[`RAM_FLAG_SECOND_HIT] = second_alarm_hit_flag_q;
		end else if (idx == `RAM_IDX_CTRL) begin
			rd_val = ctrl_q;
		end else if (idx == `RAM_IDX_IRQ_STAT) begin
			rd_val = {6'h00, irq_stat_q};
		end else if (idx == `RAM_IDX_IRQ_MASK) begin
			rd_val = {6'h00, irq_mask_q};
		end
	end

	// snapshot taken before the clearing edge, so the clearing read returns the set flag
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_i && !ack_q) begin
			rdata_q <= {24'h00_0000, rd_val};
		end
	end

	// pointer follows the last register the host touched
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ptr_q <= 5'h00;
		end else if (req && ack_q) begin
			ptr_q <= idx;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 10; i++) begin
				alarm_q[i] <= `RAM_ALARM_RST;
			end
		end else if (wr_acc) begin
			if (idx >= `RAM_IDX_A1_MONTH && idx <= `RAM_IDX_A1_SEC) begin
				alarm_q[4'(idx - `RAM_IDX_A1_MONTH)] <= avs_writedata_i[7:0];
			end else if (idx >= `RAM_IDX_A2_MONTH && idx <= `RAM_IDX_A2_SEC) begin
				// plain memory while the second alarm is off
				alarm_q[4'(idx - `RAM_IDX_A2_MONTH + 5'h05)] <= avs_writedata_i[7:0];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ctrl_q <= `RAM_CTRL_RST;
			irq_mask_q <= `RAM_MASK_RST;
		end else if (wr_acc) begin
			if (idx == `RAM_IDX_CTRL) begin
				ctrl_q <= avs_writedata_i[7:0];
			end
			if (idx == `RAM_IDX_IRQ_MASK) begin
				irq_mask_q <= avs_writedata_i[1:0];
			end
		end
	end

	assign hit1 = alarm_hit(alarm_q[0], alarm_q[1], alarm_q[2], alarm_q[3], alarm_q[4],
		time_sec_i, time_min_i, time_hour_i, time_date_i, time_month_i);
	assign hit2 = alarm_hit(alarm_q[5], alarm_q[6], alarm_q[7], alarm_q[8], alarm_q[9],
		time_sec_i, time_min_i, time_hour_i, time_date_i, time_month_i);
	assign a1_rpt = rpt_of(alarm_q[0], alarm_q[1], alarm_q[2], alarm_q[3], alarm_q[4]);
	assign a2_rpt = rpt_of(alarm_q[5], alarm_q[6], alarm_q[7], alarm_q[8], alarm_q[9]);
	// only on the second update; the pointer on the flag register blocks setting
	assign set1 = sec_tick_i & hit1 & (ptr_q != `RAM_IDX_FLAGS);
	assign set2 = sec_tick_i & hit2 & ctrl_q[`RAM_CTRL_SECOND_EN]
		& (ptr_q != `RAM_IDX_FLAGS);
	// clear only what the read returned, so a fresh hit is never lost
	assign clr1 = flags_rd & rdata_q[`RAM_FLAG_FIRST_HIT];
	assign clr2 = flags_rd & rdata_q[`RAM_FLAG_SECOND_HIT];

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			first_alarm_hit_flag_q <= 1'b0;
			second_alarm_hit_flag_q <= 1'b0;
		end else begin
			first_alarm_hit_flag_q <= set1 | (first_alarm_hit_flag_q & ~clr1);
			second_alarm_hit_flag_q <= set2 | (second_alarm_hit_flag_q & ~clr2);
		end
	end

	// interrupt outputs, gated in backup
	assign out1 = first_alarm_hit_flag_q & ctrl_q[`RAM_CTRL_FIRST_IRQ_EN]
		& ctrl_q[`RAM_CTRL_OUTEN]
		& (~backup_i | ctrl_q[`RAM_CTRL_BACKUP_EN]);
	assign out2 = second_alarm_hit_flag_q & ctrl_q[`RAM_CTRL_SECOND_IRQ_EN]
		& (~backup_i | ctrl_q[`RAM_CTRL_BACKUP_EN]);

	// a backup assertion is held until supply is back and the flags are read
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			hold1_q <= 1'b0;
			hold2_q <= 1'b0;
		end else begin
			hold1_q <= (backup_i & out1) | (hold1_q & ~(flags_rd & ~backup_i));
			hold2_q <= (backup_i & out2) | (hold2_q & ~(flags_rd & ~backup_i));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			shared_irq_test_out_o <= 1'b0;
			second_alarm_irq_out_o <= 1'b0;
		end else begin
			// outputs lag the flags by one cycle and drop after the clearing read
			shared_irq_test_out_o <= out1 | hold1_q;
			second_alarm_irq_out_o <= out2 | hold2_q;
		end
	end

	// system interrupt: sticky events, read of the status register clears
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			irq_stat_q <= 2'h0;
		end else begin
			if (rd_acc && idx == `RAM_IDX_IRQ_STAT) begin
				irq_stat_q <= {set2, set1} | (irq_stat_q & ~rdata_q[1:0]);
			end else begin
				irq_stat_q <= {set2, set1} | irq_stat_q;
			end
		end
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

	// checks look only at what this block drives or holds
	a_flag_on_hit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		set1 |=> first_alarm_hit_flag_q)
		else $error("first flag not set after hit");
	a_flag2_on_hit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		set2 |=> second_alarm_hit_flag_q)
		else $error("second flag not set after hit");
	a_no_set_no_tick: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!sec_tick_i && !first_alarm_hit_flag_q |=> !first_alarm_hit_flag_q)
		else $error("flag set without second update");
	a_ptr_blocks: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		ptr_q == `RAM_IDX_FLAGS && !second_alarm_hit_flag_q |=> !second_alarm_hit_flag_q)
		else $error("flag set while pointer on flags");
	a_ptr_blocks1: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		ptr_q == `RAM_IDX_FLAGS && !first_alarm_hit_flag_q |=> !first_alarm_hit_flag_q)
		else $error("first flag set while pointer on flags");
	a_read_clears: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		flags_rd && rdata_q[`RAM_FLAG_FIRST_HIT] && !set1 |=> !first_alarm_hit_flag_q)
		else $error("flag survived clearing read");
	a_read_clears2: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		flags_rd && rdata_q[`RAM_FLAG_SECOND_HIT] && !set2 |=> !second_alarm_hit_flag_q)
		else $error("second flag survived clearing read");
	a_read_shows: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		avs_read_i && !ack_q && idx == `RAM_IDX_FLAGS && first_alarm_hit_flag_q
		|=> avs_readdata_o[`RAM_FLAG_FIRST_HIT])
		else $error("clearing read lost the flag");
	a_alarm2_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		!ctrl_q[`RAM_CTRL_SECOND_EN] |-> !set2)
		else $error("second alarm fired while disabled");
	a_irq1_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		first_alarm_hit_flag_q && ctrl_q[`RAM_CTRL_FIRST_IRQ_EN] && ctrl_q[`RAM_CTRL_OUTEN]
		&& !backup_i |=> shared_irq_test_out_o)
		else $error("shared output missing");
	a_second_alarm_irq_out_follow: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		second_alarm_hit_flag_q && ctrl_q[`RAM_CTRL_SECOND_IRQ_EN] && !backup_i
		|=> second_alarm_irq_out_o)
		else $error("second output missing");
	a_irq1_backup: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		backup_i && !ctrl_q[`RAM_CTRL_BACKUP_EN] && !hold1_q |=> !shared_irq_test_out_o)
		else $error("shared output driven in backup without enable");
	a_second_alarm_irq_out_backup: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		backup_i && !(ctrl_q[`RAM_CTRL_BACKUP_EN] && ctrl_q[`RAM_CTRL_SECOND_IRQ_EN])
		&& !hold2_q |=> !second_alarm_irq_out_o)
		else $error("second output driven in backup without enables");
	a_backup_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		hold1_q && backup_i |=> shared_irq_test_out_o && hold1_q)
		else $error("backup assertion released in backup");
	a_irq1_drop: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(first_alarm_hit_flag_q) && !hold1_q && !second_alarm_hit_flag_q
		|=> !shared_irq_test_out_o)
		else $error("shared output stuck after clear");
	a_second_alarm_irq_out_drop: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(second_alarm_hit_flag_q) && !hold2_q |=> !second_alarm_irq_out_o)
		else $error("second output stuck after clear");
	a_disabled_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		a1_rpt == 5'h00 && alarm_q[1][5:0] == 6'h00 |-> !hit1)
		else $error("disabled alarm matched");
	a_disabled_quiet2: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		a2_rpt == 5'h00 && alarm_q[6][5:0] == 6'h00 |-> !hit2)
		else $error("disabled second alarm matched");
	a_bad_code_sec: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		a1_rpt == 5'h15 |-> hit1)
		else $error("undefined repeat code not once per second");
	a_minute_mode: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		a1_rpt == 5'h1e && alarm_q[4][6:0] != time_sec_i |-> !hit1)
		else $error("minute mode matched a wrong second");
	a_year_mode: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		a1_rpt == 5'h00 && alarm_q[0][4:0] != time_month_i |-> !hit1)
		else $error("year mode matched a wrong month");
	a_reset_ctrl: assert property (@(posedge core_clk_i)
		$rose(rstn_i) |-> !ctrl_q[`RAM_CTRL_SECOND_EN])
		else $error("second alarm enabled after reset");
	a_user_mem: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		wr_acc && idx == `RAM_IDX_A2_SEC |=> alarm_q[9] == $past(avs_writedata_i[7:0]))
		else $error("second alarm byte not written");
	a_no_be_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		avs_write_i && ack_q && !avs_byteenable_i[0] |=> $stable(ctrl_q) && $stable(alarm_q[5]))
		else $error("write without byte enable took effect");
	a_stat_sticky: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		set1 |=> irq_stat_q[0])
		else $error("status bit not set on hit");
	a_stat_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
		rd_acc && idx == `RAM_IDX_IRQ_STAT && rdata_q[0] && !set1 |=> !irq_stat_q[0])
		else $error("status bit survived its read");

	c_flag_read: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		flags_rd && rdata_q[`RAM_FLAG_FIRST_HIT]);
	c_byte_refused: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		avs_write_i && ack_q && !avs_byteenable_i[0]);
	c_alarm2_irq: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(second_alarm_irq_out_o));
	c_backup_hold: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		hold1_q && !backup_i);
	c_set_and_clear: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
		set1 && clr1);

endmodule

// ---- src/ram_consts.svh ----
// Purpose: register indices, field positions and reset values of the alarm match unit
// Assumes: byte address of a register is four times its index
// Notes: included by the package users and the design
`ifndef RAM_CONSTS_SVH
`define RAM_CONSTS_SVH

`define RAM_IDX_A1_MONTH 5'h0a
`define RAM_IDX_A1_SEC 5'h0e
`define RAM_IDX_FLAGS 5'h0f
`define RAM_IDX_CTRL 5'h13
`define RAM_IDX_A2_MONTH 5'h14
`define RAM_IDX_A2_SEC 5'h18
`define RAM_IDX_IRQ_STAT 5'h19
`define RAM_IDX_IRQ_MASK 5'h1a

`define RAM_FLAG_FIRST_HIT 6
`define RAM_FLAG_SECOND_HIT 5

`define RAM_CTRL_FIRST_IRQ_EN 7
`define RAM_CTRL_SECOND_IRQ_EN 6
`define RAM_CTRL_BACKUP_EN 5
`define RAM_CTRL_OUTEN 4
`define RAM_CTRL_SECOND_EN 1

`define RAM_ALARM_RPT_BIT 7
`define RAM_CTRL_RST 8'h00
`define RAM_ALARM_RST 8'h00
`define RAM_MASK_RST 2'h0

`endif

// ---- src/ram_pkg.sv ----
// Purpose: types of the alarm match unit
// Assumes: nothing beyond the constants header
// Notes: repeat modes decoded from the five repeat bits
package ram_pkg;
	typedef enum logic [2:0] {
		RAM_EVERY_SEC = 3'h0,
		RAM_EVERY_MIN = 3'h1,
		RAM_EVERY_HOUR = 3'h2,
		RAM_EVERY_DAY = 3'h3,
		RAM_EVERY_MONTH = 3'h4,
		RAM_EVERY_YEAR = 3'h5
	} ram_mode_t;
endpackage

// ---- tb/ram_time_src.sv ----
// Purpose: seconds counter chain model feeding time values and the update tick
// Assumes: time fields packed sec,min,hour,date,month, highest first
// Notes: values stay put between ticks, like real counters between updates
`timescale 1ns/10ps
module ram_time_src (
	input wire logic core_clk_i,
	output logic sec_tick_o,
	output logic [6:0] sec_o,
	output logic [6:0] min_o,
	output logic [5:0] hour_o,
	output logic [5:0] date_o,
	output logic [4:0] month_o
);
	initial begin
		sec_tick_o = 1'b0;
		{sec_o, min_o, hour_o, date_o, month_o} = 31'h0;
	end
	// one-cycle tick: a longer pulse could hide a double evaluation
	task automatic tick(input logic [30:0] t);
		@(posedge core_clk_i);
		sec_tick_o <= 1'b1;
		{sec_o, min_o, hour_o, date_o, month_o} <= t;
		@(posedge core_clk_i);
		sec_tick_o <= 1'b0;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench of the alarm match unit over its register port
// Assumes: waitrequest may stay high any number of cycles, interrupts two edges after the tick
// Notes: one write runs with byteenable cleared and must leave the register alone
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [6:0] adr = 7'h00;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata;
	logic wq, shared, sec2, irq, tick, bk;
	logic [6:0] ts, tm;
	logic [5:0] th, td;
	logic [4:0] tmo;
	logic [30:0] t;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] bv[5] = '{8'h30, 8'h15, 8'h12, 8'h05, 8'h03};
	logic [7:0] av[5] = '{8'h50, 8'h44, 8'h08, 8'h09, 8'h07};
	logic [4:0] codes[6] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00};
	always #50 clk = ~clk;
	initial bk = 1'b0;
	ram_time_src u_ram_time_src (.core_clk_i(clk), .sec_tick_o(tick), .sec_o(ts),
		.min_o(tm), .hour_o(th), .date_o(td), .month_o(tmo));
	ram_alarm_unit u_ram_alarm_unit (.core_clk_i(clk), .rstn_i(rstn), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wq),
		.sec_tick_i(tick), .time_sec_i(ts), .time_min_i(tm), .time_hour_i(th),
		.time_date_i(td), .time_month_i(tmo), .backup_i(bk),
		.shared_irq_test_out_o(shared), .second_alarm_irq_out_o(sec2), .irq_o(irq));
	task automatic close_out;
		if (failures == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] wd,
		output logic [7:0] v);
		@(posedge clk);
		adr <= {idx, 2'b00};
		rd_s <= !w;
		wr_s <= w;
		wdat <= {24'h0, wd};
		@(negedge clk);
		// only the watchdog ends a wait that never comes
		while (wq !== 1'b0) @(negedge clk);
		@(posedge clk);
		v = rdata[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] idx, input logic [7:0] wd);
		logic [7:0] v;
		bus(1'b1, idx, wd, v);
	endtask
	task automatic rdc(input logic [4:0] idx, input logic [7:0] e);
		logic [7:0] v;
		bus(1'b0, idx, 8'h00, v);
		chk($sformatf("register %h", idx), e, v);
	endtask
	task automatic edge1;
		@(posedge clk);
		@(negedge clk);
	endtask
	task automatic pins(input logic sh, input logic s2);
		chk("shared irq", {7'h0, sh}, {7'h0, shared});
		chk("second irq", {7'h0, s2}, {7'h0, sec2});
	endtask
	function automatic logic [30:0] pk(int k);
		logic [7:0] f[5];
		f = bv;
		if (k < 5) f[k] = av[k];
		return {f[0][6:0], f[1][6:0], f[2][5:0], f[3][5:0], f[4][4:0]};
	endfunction
	// field k sits k below the seconds byte; its repeat bit is code bit k
	task automatic set_al(input logic [4:0] sidx, input logic [4:0] code);
		for (int k = 0; k < 5; k++) wr(sidx - 5'(k), {code[k], bv[k][6:0]});
	endtask
	// pointer is moved off the flag register first, else no flag can set
	task automatic hit(input logic [30:0] tt, input logic [7:0] fl, input logic sh,
		input logic s2);
		logic [7:0] v;
		bus(1'b0, 5'h1a, 8'h00, v);
		u_ram_time_src.tick(tt);
		pins(sh, s2);
		rdc(5'h0f, fl);
		edge1();
		pins(1'b0, 1'b0);
	endtask
	initial begin
		#2_000_000;
		failures++;
		close_out();
	end
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(5'h13, 8'h00);
		rdc(5'h0f, 8'h00);
		wr(5'h14, 8'ha5);
		rdc(5'h14, 8'ha5);
		be <= 4'h0;
		wr(5'h14, 8'h5a);
		be <= 4'hf;
		rdc(5'h14, 8'ha5);
		wr(5'h1f, 8'h3c);
		rdc(5'h1f, 8'h00);
		set_al(5'h18, 5'h1f);
		hit(pk(5), 8'h00, 1'b0, 1'b0);
		wr(5'h13, 8'h90);
		wr(5'h1a, 8'h01);
		set_al(5'h0e, 5'h15);
		hit(pk(1), 8'h40, 1'b1, 1'b0);
		chk("irq", 8'h01, {7'h0, irq});
		rdc(5'h19, 8'h01);
		edge1();
		chk("irq", 8'h00, {7'h0, irq});
		rdc(5'h0f, 8'h00);
		u_ram_time_src.tick(pk(5));
		rdc(5'h0f, 8'h00);
		wr(5'h1a, 8'h00);
		for (int m = 0; m < 6; m++) begin
			set_al(5'h0e, codes[m]);
			hit(pk(m), 8'h40, 1'b1, 1'b0);
			if (m > 0) hit(pk(m - 1), 8'h00, 1'b0, 1'b0);
		end
		chk("irq", 8'h00, {7'h0, irq});
		set_al(5'h0e, 5'h00);
		wr(5'h0b, 8'h00);
		t = pk(5);
		t[10:5] = 6'h00;
		hit(t, 8'h00, 1'b0, 1'b0);
		wr(5'h13, 8'h42);
		hit(pk(5), 8'h20, 1'b0, 1'b1);
		set_al(5'h0e, 5'h1f);
		wr(5'h13, 8'hd2);
		@(posedge clk);
		bk <= 1'b1;
		hit(pk(5), 8'h60, 1'b0, 1'b0);
		wr(5'h13, 8'hf2);
		u_ram_time_src.tick(pk(5));
		pins(1'b1, 1'b1);
		rdc(5'h0f, 8'h60);
		edge1();
		pins(1'b1, 1'b1);
		@(posedge clk);
		bk <= 1'b0;
		rdc(5'h0f, 8'h00);
		edge1();
		pins(1'b0, 1'b0);
		close_out();
	end
endmodule
